// file: extirq_chan.sv
// one extra external interrupt channel: edge detect and pending flag
`timescale 1ns/1ns
module extirq_chan (
    input  wire logic I_SYS_CLK,
    input  wire logic I_RST,
    input  wire logic i_pin_n,
    input  wire logic i_edge_sel,
    input  wire logic i_wr_pend,
    input  wire logic i_wr_val,
    input  wire logic i_serviced,
    output logic      o_pending
);
    logic pin_prev;
    logic next_pin_prev;
    logic pend;
    logic next_pend;
    logic fall;

    // falling edge and pending flag; set wins over any clear
    always_comb begin
        fall          = pin_prev & ~i_pin_n;
        next_pin_prev = i_pin_n;
        next_pend     = pend;
        if (i_edge_sel) begin
            if (i_wr_pend)
                next_pend = i_wr_val;
            else if (i_serviced)
                next_pend = 1'b0;
            if (fall)
                next_pend = 1'b1;
        end else begin
            next_pend = ~i_pin_n;
        end
    end

    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            pin_prev <= 1'b1;
            pend     <= 1'b0;
        end else begin
            pin_prev <= next_pin_prev;
            pend     <= next_pend;
        end
    end

    assign o_pending = pend;
endmodule : extirq_chan

// file: extirq_map.svh
// register offsets, field positions and reset values of the extension registers
`ifndef EXTIRQ_MAP_SVH
`define EXTIRQ_MAP_SVH
`define EXT_ADDR_PAGE_HIGH   8'hA1
`define EXT_ADDR_BANK_SEL    8'hA2
`define EXT_ADDR_AUX_PORT    8'hA6
`define EXT_ADDR_IRQ_CTRL    8'hC0
`define EXT_RST_PAGE_HIGH    8'h00
`define EXT_RST_BANK_SEL     8'h70
`define EXT_RST_AUX_PORT     8'hFF
`define EXT_RST_IRQ_CTRL     8'h00
`define EXT_BANK_RSVD_READ   3'h7
`define EXT_BIT_A_EDGE       0
`define EXT_BIT_A_PEND       1
`define EXT_BIT_A_EN         2
`define EXT_BIT_A_PRIO       3
`define EXT_BIT_B_EDGE       4
`define EXT_BIT_B_PEND       5
`define EXT_BIT_B_EN         6
`define EXT_BIT_B_PRIO       7
`define EXT_BIT_BANK_MODE    7
`define EXT_VEC_A            8'h33
`define EXT_VEC_B            8'h3B
`define EXT_BITADDR_BASE     8'hC0
`endif

// file: extirq_pins.sv
// upper bank pin selection between bank bits and chip selects
`timescale 1ns/1ns
module extirq_pins (
    input  wire logic       i_cs_mode,
    input  wire logic [3:0] i_bank_bits,
    input  wire logic       i_ext_data,
    input  wire logic [1:0] i_hi_bits,
    output logic      [3:0] o_pins
);
    // chip select low per 16K block, else bank bits during data moves
    always_comb begin
        if (i_cs_mode)
            o_pins = ~(4'h1 << i_hi_bits);
        else if (i_ext_data)
            o_pins = i_bank_bits;
        else
            o_pins = 4'h0;
    end
endmodule : extirq_pins

// file: extirq_pkg.sv
// types shared by the extension register block
package extirq_pkg;
    typedef enum logic [1:0] {
        EXTIRQ_RUN   = 2'b00,
        EXTIRQ_IDLE  = 2'b01,
        EXTIRQ_PDOWN = 2'b10
    } extirq_pmode_e;
    typedef logic [7:0] extirq_byte_t;
endpackage : extirq_pkg

// file: extirq_properties.sv
// port assertions for the extension register block
`timescale 1ns/1ns
module extirq_props (
    input wire logic       I_SYS_CLK,
    input wire logic       I_RST,
    input wire logic [7:0] i_sfr_addr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic       i_sfr_wr,
    input wire logic       i_sfr_rd,
    input wire logic [1:0] i_power_mode,
    input wire logic [7:0] o_sfr_rdata,
    input wire logic       o_sfr_hit,
    input wire logic       o_irq_req,
    input wire logic [7:0] o_irq_vector,
    input wire logic [7:0] o_aux_port,
    input wire logic       o_addr_latch_strobe,
    input wire logic       o_program_store_enable_n,
    input wire logic       o_data_bus_oe
);
    // one clock domain, all checks idle in reset
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);
    a_idle_pins: assert property (i_power_mode == 2'b01 |-> o_addr_latch_strobe
        && o_program_store_enable_n && !o_data_bus_oe) else $error("idle pins wrong");
    a_pdown_pins: assert property (i_power_mode == 2'b10 |-> !o_addr_latch_strobe
        && !o_program_store_enable_n && !o_data_bus_oe) else $error("sleep pins wrong");
    a_aux_write: assert property (i_sfr_wr && i_sfr_addr == 8'hA6
        |=> o_aux_port == $past(i_sfr_wdata)) else $error("latch not written");
    a_bank_rsvd: assert property (i_sfr_rd && i_sfr_addr == 8'hA2
        |=> o_sfr_rdata[6:4] == 3'h7) else $error("reserved bits wrong");
    a_irq_vector: assert property (o_irq_req
        |-> o_irq_vector inside {8'h33, 8'h3B}) else $error("bad vector");
    a_rdata_hold: assert property (!i_sfr_rd |=> $stable(o_sfr_rdata))
        else $error("read data moved");
    a_hit_map: assert property (o_sfr_hit == (i_sfr_addr inside
        {8'hA1, 8'hA2, 8'hA6, 8'hC0})) else $error("bad hit");
    a_unmapped_zero: assert property (i_sfr_rd && !o_sfr_hit |=> o_sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule : extirq_props
bind extirq_top extirq_props u_props (
    .I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata),
    .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_power_mode(i_power_mode),
    .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit), .o_irq_req(o_irq_req),
    .o_irq_vector(o_irq_vector), .o_aux_port(o_aux_port),
    .o_addr_latch_strobe(o_addr_latch_strobe), .o_data_bus_oe(o_data_bus_oe),
    .o_program_store_enable_n(o_program_store_enable_n)
);

// file: extirq_src.sv
// interrupt source model behind the two active-low pins
`timescale 1ns/1ns
module extirq_src (
    input  wire logic I_SYS_CLK,
    input  wire logic i_fire_a,
    input  wire logic i_fire_b,
    output logic      o_pin_a_n,
    output logic      o_pin_b_n
);
    // pins rest high on pull-ups, pulled low one edge after a fire
    initial begin
        {o_pin_a_n, o_pin_b_n} = 2'b11;
        forever @(posedge I_SYS_CLK) {o_pin_a_n, o_pin_b_n} <= {!i_fire_a, !i_fire_b};
    end
endmodule : extirq_src

// file: extirq_top.sv
// extension special function registers and two extra external interrupts
// Overview of operation
// - bit 7 sets high priority, input b
// - bit 3 sets high priority, input a
// - bits 6 and 2 enable inputs b, a
// - bits 4 and 0 pick falling edge
// - edge pending set by hardware, cleared on service
// - vectors 33H and 3BH, polled a before b
// - page-high drives high address on indirect moves
// - page-high has byte access only
// - bank bit 7 mode; bits 3:0 drive pins
// - port latch drives pins, resets all ones
// - only control register takes bit operations
// - idle: strobes high, data floats, address held
// - power-down: strobes low, data floats, address held
// - sleep bank pins zero or chip select
// - extra inputs behave like standard ones
// - chip select one low per 16K block
// - bank bits 6 to 4 read ones
`timescale 1ns/1ns
`include "extirq_map.svh"
module extirq_top
    import extirq_pkg::*;
(
    input  wire logic       I_SYS_CLK,
    input  wire logic       I_RST,
    input  wire logic [7:0] i_sfr_addr,
    input  wire logic [7:0] i_sfr_wdata,
    input  wire logic       i_sfr_wr,
    input  wire logic       i_sfr_rd,
    input  wire logic [7:0] i_bit_addr,
    input  wire logic       i_bit_wr,
    input  wire logic       i_bit_val,
    output logic      [7:0] o_sfr_rdata,
    output logic            o_sfr_hit,
    output logic            o_bit_rdata,
    input  wire logic       i_irq_a_pin_n,
    input  wire logic       i_irq_b_pin_n,
    input  wire logic       i_core_irq_active,
    input  wire logic       i_core_irq_high,
    input  wire logic       i_irq_ack,
    input  wire logic [7:0] i_ack_vector,
    output logic            o_irq_req,
    output logic      [7:0] o_irq_vector,
    output logic            o_irq_high,
    input  wire logic       i_indirect_move,
    input  wire logic       i_ext_data_move,
    input  wire logic [7:0] i_index_low,
    input  wire logic [15:0] i_core_addr,
    input  wire logic       i_core_strobe,
    input  wire logic       i_core_pse_n,
    input  wire logic       i_core_data_oe,
    input  wire logic [1:0] i_power_mode,
    output logic      [7:0] o_addr_low_port,
    output logic      [7:0] o_addr_high_port,
    output logic      [3:0] o_bank_select_pins,
    output logic      [7:0] o_aux_port,
    output logic            o_addr_latch_strobe,
    output logic            o_program_store_enable_n,
    output logic            o_data_bus_oe
);
    extirq_byte_t movx_page_high, next_movx_page_high;
    extirq_byte_t upper_bank_select, next_upper_bank_select;
    extirq_byte_t aux_port_latch, next_aux_port_latch;
    extirq_byte_t extra_irq_control, next_extra_irq_control;
    extirq_pmode_e pmode;
    logic [7:0] next_rdata, rdata;
    logic       pend_a, pend_b;
    logic       wr_pa, wr_pb, wval_a, wval_b;
    logic       svc_a, svc_b;
    logic       req_a, req_b, any_high;
    logic [15:0] eff_addr;

    // bit-address match into the control register only
    function automatic logic bit_hit(input logic [7:0] ba, input int unsigned pos);
        bit_hit = (ba == (`EXT_BITADDR_BASE + pos[7:0]));
    endfunction : bit_hit

    // bit address lands in the control register's bit range
    function automatic logic ctrl_bit_sel(input logic [7:0] ba);
        ctrl_bit_sel = (ba[7:3] == 5'(`EXT_BITADDR_BASE >> 3));
    endfunction : ctrl_bit_sel

    assign pmode = extirq_pmode_e'(i_power_mode);

    // byte writes to the four registers, bit writes to control only
    always_comb begin
        next_movx_page_high    = movx_page_high;
        next_upper_bank_select = upper_bank_select;
        next_aux_port_latch    = aux_port_latch;
        next_extra_irq_control = extra_irq_control;
        if (i_sfr_wr) begin
            case (i_sfr_addr)
                `EXT_ADDR_PAGE_HIGH: next_movx_page_high = i_sfr_wdata;
                `EXT_ADDR_BANK_SEL:  next_upper_bank_select = i_sfr_wdata;
                `EXT_ADDR_AUX_PORT:  next_aux_port_latch = i_sfr_wdata;
                `EXT_ADDR_IRQ_CTRL:  next_extra_irq_control = i_sfr_wdata;
                default: ;
            endcase
        end
        if (i_bit_wr && ctrl_bit_sel(i_bit_addr))
            next_extra_irq_control[i_bit_addr[2:0]] = i_bit_val;
        // pending bits are owned by the channels
        next_extra_irq_control[`EXT_BIT_A_PEND] = pend_a;
        next_extra_irq_control[`EXT_BIT_B_PEND] = pend_b;
    end

    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            movx_page_high    <= `EXT_RST_PAGE_HIGH;
            upper_bank_select <= `EXT_RST_BANK_SEL;
            aux_port_latch    <= `EXT_RST_AUX_PORT;
            extra_irq_control <= `EXT_RST_IRQ_CTRL;
        end else begin
            movx_page_high    <= next_movx_page_high;
            upper_bank_select <= next_upper_bank_select;
            aux_port_latch    <= next_aux_port_latch;
            extra_irq_control <= next_extra_irq_control;
        end
    end

    // software writes to the pending bits
    always_comb begin
        wr_pa  = (i_sfr_wr && i_sfr_addr == `EXT_ADDR_IRQ_CTRL)
               || (i_bit_wr && bit_hit(i_bit_addr, `EXT_BIT_A_PEND));
        wr_pb  = (i_sfr_wr && i_sfr_addr == `EXT_ADDR_IRQ_CTRL)
               || (i_bit_wr && bit_hit(i_bit_addr, `EXT_BIT_B_PEND));
        wval_a = i_bit_wr ? i_bit_val : i_sfr_wdata[`EXT_BIT_A_PEND];
        wval_b = i_bit_wr ? i_bit_val : i_sfr_wdata[`EXT_BIT_B_PEND];
        svc_a  = i_irq_ack && (i_ack_vector == `EXT_VEC_A);
        svc_b  = i_irq_ack && (i_ack_vector == `EXT_VEC_B);
    end

    extirq_chan u_chan_a (
        .I_SYS_CLK  (I_SYS_CLK),
        .I_RST      (I_RST),
        .i_pin_n    (i_irq_a_pin_n),
        .i_edge_sel (extra_irq_control[`EXT_BIT_A_EDGE]),
        .i_wr_pend  (wr_pa),
        .i_wr_val   (wval_a),
        .i_serviced (svc_a),
        .o_pending  (pend_a)
    );

    extirq_chan u_chan_b (
        .I_SYS_CLK  (I_SYS_CLK),
        .I_RST      (I_RST),
        .i_pin_n    (i_irq_b_pin_n),
        .i_edge_sel (extra_irq_control[`EXT_BIT_B_EDGE]),
        .i_wr_pend  (wr_pb),
        .i_wr_val   (wval_b),
        .i_serviced (svc_b),
        .o_pending  (pend_b)
    );

    // request arbitration: enable, priority level, then polling order
    always_comb begin
        req_a    = pend_a & extra_irq_control[`EXT_BIT_A_EN];
        req_b    = pend_b & extra_irq_control[`EXT_BIT_B_EN];
        any_high = (req_a & extra_irq_control[`EXT_BIT_A_PRIO])
                 | (req_b & extra_irq_control[`EXT_BIT_B_PRIO]);
        o_irq_req    = 1'b0;
        o_irq_vector = 8'h00;
        o_irq_high   = 1'b0;
        if (any_high && !(i_core_irq_active && i_core_irq_high)) begin
            o_irq_req  = 1'b1;
            o_irq_high = 1'b1;
            if (req_a && extra_irq_control[`EXT_BIT_A_PRIO])
                o_irq_vector = `EXT_VEC_A;
            else
                o_irq_vector = `EXT_VEC_B;
        end else if ((req_a || req_b) && !i_core_irq_active) begin
            o_irq_req    = 1'b1;
            o_irq_vector = req_a ? `EXT_VEC_A : `EXT_VEC_B;
        end
    end

    // register read data, registered for the core
    always_comb begin
        next_rdata = 8'h00;
        case (i_sfr_addr)
            `EXT_ADDR_PAGE_HIGH: next_rdata = movx_page_high;
            `EXT_ADDR_BANK_SEL:  next_rdata = {upper_bank_select[7], `EXT_BANK_RSVD_READ,
                                               upper_bank_select[3:0]};
            `EXT_ADDR_AUX_PORT:  next_rdata = aux_port_latch;
            `EXT_ADDR_IRQ_CTRL:  next_rdata = extra_irq_control;
            default:             next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST)
            rdata <= 8'h00;
        else if (i_sfr_rd)
            rdata <= next_rdata;
    end

    assign o_sfr_rdata = rdata;
    assign o_sfr_hit   = (i_sfr_addr == `EXT_ADDR_PAGE_HIGH) || (i_sfr_addr == `EXT_ADDR_BANK_SEL)
                      || (i_sfr_addr == `EXT_ADDR_AUX_PORT) || (i_sfr_addr == `EXT_ADDR_IRQ_CTRL);
    assign o_bit_rdata = ctrl_bit_sel(i_bit_addr)
                       ? extra_irq_control[i_bit_addr[2:0]] : 1'b0;

    // address ports: page-high replaces high byte on indirect moves
    always_comb begin
        eff_addr = i_indirect_move ? {movx_page_high, i_index_low} : i_core_addr;
    end

    assign o_addr_low_port  = eff_addr[7:0];
    assign o_addr_high_port = eff_addr[15:8];
    assign o_aux_port       = aux_port_latch;

    extirq_pins u_pins (
        .i_cs_mode   (upper_bank_select[`EXT_BIT_BANK_MODE]),
        .i_bank_bits (upper_bank_select[3:0]),
        .i_ext_data  (i_ext_data_move && (pmode == EXTIRQ_RUN)),
        .i_hi_bits   (eff_addr[15:14]),
        .o_pins      (o_bank_select_pins)
    );

    // strobes and data bus in idle and power-down
    always_comb begin
        case (pmode)
            EXTIRQ_IDLE: begin
                o_addr_latch_strobe      = 1'b1;
                o_program_store_enable_n = 1'b1;
                o_data_bus_oe            = 1'b0;
            end
            EXTIRQ_PDOWN: begin
                o_addr_latch_strobe      = 1'b0;
                o_program_store_enable_n = 1'b0;
                o_data_bus_oe            = 1'b0;
            end
            default: begin
                o_addr_latch_strobe      = i_core_strobe;
                o_program_store_enable_n = i_core_pse_n;
                o_data_bus_oe            = i_core_data_oe;
            end
        endcase
    end
endmodule : extirq_top

// file: testbench.sv
// self-checking bench for the extension register block
`timescale 1ns/1ns
module testbench;
    logic        clk, rst, wr, rd, bwr, act, hi, ack, imv, xmv, stb, fa, fb, bv;
    logic        hit, brd, req, ihi, ale, pse, dbo, pa, pb;
    logic [7:0]  addr, wd, badr, ackv, idx, rdat, vec, alo, ahi, aux, v, d;
    logic [15:0] cad;
    logic [3:0]  bsp;
    logic [1:0]  pm;
    logic [7:0]  ra [5] = '{8'hA1, 8'hA2, 8'hA6, 8'hC0, 8'h55};
    logic [7:0]  rv [5] = '{8'h00, 8'h70, 8'hFF, 8'h00, 8'h00};
    logic [7:0]  ba [3] = '{8'hA1, 8'hA2, 8'hC2};
    int          errors = 0;
    int          checks = 0;
    extirq_top u_dut (
        .I_SYS_CLK(clk), .I_RST(rst), .i_sfr_addr(addr), .i_sfr_wdata(wd), .i_sfr_wr(wr),
        .i_sfr_rd(rd), .i_bit_addr(badr), .i_bit_wr(bwr), .i_bit_val(bv),
        .o_sfr_rdata(rdat), .o_sfr_hit(hit), .o_bit_rdata(brd), .i_irq_a_pin_n(pa),
        .i_irq_b_pin_n(pb), .i_core_irq_active(act), .i_core_irq_high(hi), .i_irq_ack(ack),
        .i_ack_vector(ackv), .o_irq_req(req), .o_irq_vector(vec), .o_irq_high(ihi),
        .i_indirect_move(imv), .i_ext_data_move(xmv), .i_index_low(idx), .i_core_addr(cad),
        .i_core_strobe(stb), .i_core_pse_n(stb), .i_core_data_oe(!stb), .i_power_mode(pm),
        .o_addr_low_port(alo), .o_addr_high_port(ahi), .o_bank_select_pins(bsp),
        .o_aux_port(aux), .o_addr_latch_strobe(ale), .o_program_store_enable_n(pse),
        .o_data_bus_oe(dbo)
    );
    extirq_src u_src (.I_SYS_CLK(clk), .i_fire_a(fa), .i_fire_b(fb), .o_pin_a_n(pa),
        .o_pin_b_n(pb));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (e !== s) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // one register access, write or read, data taken after the answer edge
    task automatic op(input logic w, input logic [7:0] a, input logic [7:0] dv);
        @(posedge clk) {addr, wd, wr, rd} <= {a, dv, w, !w};
        @(posedge clk) {wr, rd} <= 2'b00;
        #1 v = rdat;
    endtask : op
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    function automatic logic [7:0] bank_rd(input logic [7:0] w);
        return {w[7], 3'h7, w[3:0]};
    endfunction : bank_rd
    task automatic complete_run();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run
    // clock and watchdog
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #100000;
        errors++;
        complete_run();
    end
    // register, pin and interrupt scenarios
    initial begin
        {rst, wr, rd, bwr, act, hi, ack, imv, xmv, stb, fa, fb} = 12'h800;
        {addr, wd, badr, ackv, idx, cad, pm} = '0;
        bv = 1'b1;
        void'($urandom(30));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        foreach (ra[i]) begin
            op(1'b0, ra[i], 8'h00);
            chk("reset", rv[i], v);
        end
        @(posedge clk) imv <= 1'b1;
        repeat (16) begin
            d = 8'($urandom);
            op(1'b1, 8'hA2, d);
            op(1'b0, 8'hA2, d);
            chk("bank", bank_rd(d), v);
            op(1'b1, 8'hA6, d);
            chk("aux", d, aux);
            @(posedge clk) idx <= ~d;
            op(1'b1, 8'hA1, d);
            chk("ports", {d, ~d}, {ahi, alo});
        end
        op(1'b1, 8'hA1, 8'h00);
        foreach (ba[i]) @(posedge clk) {badr, bwr} <= {ba[i], 1'b1};
        @(posedge clk) bwr <= 1'b0;
        op(1'b0, 8'hA1, 8'h00);
        chk("page", 8'h00, v);
        op(1'b0, 8'hC0, 8'h00);
        chk("control", 9'h104, {brd, v});
        op(1'b0, 8'hA2, 8'h00);
        chk("bank bits", bank_rd(d), v);
        @(posedge clk) {badr, bwr, bv} <= {8'hC2, 2'b10};
        @(posedge clk) bwr <= 1'b0;
        step(1);
        chk("bit clear", 1'b0, brd);
        @(posedge clk) {imv, xmv} <= 2'b01;
        op(1'b1, 8'hA2, 8'h05);
        chk("bank pins", 4'h5, bsp);
        op(1'b1, 8'hA2, 8'h80);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk) cad <= {k[1:0], 14'($urandom)};
            step(1);
            chk("select", 4'(~(4'h1 << k)), bsp);
        end
        for (int m = 1; m < 3; m++) begin
            @(posedge clk) pm <= 2'(m);
            op(1'b1, 8'hA2, 8'h05);
            chk("sleep pins", 4'h0, bsp);
            op(1'b1, 8'hA2, 8'h80);
            chk("sleep select", 4'(~(4'h1 << cad[15:14])), bsp);
            chk("strobes", {{2{m == 1}}, 1'b0}, {ale, pse, dbo});
            chk("held", {d, cad}, {aux, ahi, alo});
        end
        @(posedge clk) {pm, stb} <= 3'b001;
        step(1);
        chk("run strobes", 3'b110, {ale, pse, dbo});
        op(1'b1, 8'hC0, 8'h50);
        @(posedge clk) fb <= 1'b1;
        step(3);
        chk("edge b", 10'h23B, {req, ihi, vec});
        op(1'b0, 8'hC0, 8'h00);
        chk("pending", 8'h70, v);
        @(posedge clk) {ack, ackv} <= {1'b1, 8'h3B};
        @(posedge clk) ack <= 1'b0;
        step(1);
        chk("serviced", 1'b0, req);
        @(posedge clk) fa <= 1'b1;
        op(1'b1, 8'hC0, 8'h44);
        step(1);
        chk("tie", 10'h233, {req, ihi, vec});
        op(1'b1, 8'hC0, 8'hC4);
        chk("b high", 10'h33B, {req, ihi, vec});
        @(posedge clk) act <= 1'b1;
        op(1'b1, 8'hC0, 8'h0C);
        chk("preempt", 10'h333, {req, ihi, vec});
        @(posedge clk) hi <= 1'b1;
        step(1);
        chk("nested", 1'b0, req);
        @(posedge clk) {act, hi, fa} <= 3'b000;
        step(3);
        chk("level", 1'b0, req);
        complete_run();
    end
endmodule : testbench
